// *** sim/dbg_core_model.sv ***
/* core read side: fixed pc value 16'h4c21, register data combinational from the address */
`timescale 1ns/1ps
module dbg_core_model (
	input  wire logic [11:0] i_addr,
	output logic      [15:0] o_pc,
	output logic      [7:0]  o_rdat
);
	assign o_pc = 16'h4c21;
	assign o_rdat = i_addr[7:0] ^ 8'ha5;
endmodule

// *** sim/dbg_gate_asserts.sv ***
/* gate checker on top ports; assumes one clock, async low reset */
`timescale 1ns/1ps
module dbg_gate_asserts (
	input wire logic       i_sys_clk, i_rst_n, i_cmd_valid, i_read_protect_option,
	input wire logic       i_watchpoint_hit, i_breakpoint_hit, o_resp_valid, o_cmd_rejected,
	input wire logic       o_debug_mode_flag,
	input wire logic [7:0] i_cmd_code, o_debug_ctl
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_one_answer: assert property (i_cmd_valid |=> o_resp_valid != o_cmd_rejected)
		else $error("not one answer");
	a_idle_quiet: assert property (!i_cmd_valid |=> !o_resp_valid && !o_cmd_rejected)
		else $error("answer without command");
	a_watch_enter: assert property (i_watchpoint_hit |=> o_debug_mode_flag)
		else $error("no debug entry");
	a_rsvd_refused: assert property (i_cmd_valid && i_cmd_code == 8'h01 |=> o_cmd_rejected)
		else $error("reserved accepted");
	a_always_ok: assert property (
		i_cmd_valid && i_cmd_code inside {8'h00, 8'h02, 8'h04, 8'h05} |=> o_resp_valid)
		else $error("open command refused");
	a_idle_refuse: assert property (
		i_cmd_valid && !o_debug_mode_flag && i_cmd_code inside {8'h03, [8'h06:8'h09]}
		|=> o_cmd_rejected) else $error("debug command taken");
	a_prot_refuse: assert property (
		i_cmd_valid && i_read_protect_option && i_cmd_code inside {8'h06, 8'h07, 8'h09}
		|=> o_cmd_rejected) else $error("protected command taken");
	a_prot_keep: assert property (i_read_protect_option && o_debug_mode_flag
		|=> o_debug_mode_flag) else $error("debug flag cleared");
	a_ctl_stable: assert property (!i_cmd_valid && !i_watchpoint_hit && !i_breakpoint_hit
		|=> $stable(o_debug_ctl)) else $error("control changed");
endmodule
bind debug_command_gate_runtime_counter dbg_gate_asserts chk_i (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_read_protect_option(i_read_protect_option),
	.i_watchpoint_hit(i_watchpoint_hit), .i_breakpoint_hit(i_breakpoint_hit),
	.o_resp_valid(o_resp_valid), .o_cmd_rejected(o_cmd_rejected), .i_cmd_code(i_cmd_code),
	.o_debug_mode_flag(o_debug_mode_flag), .o_debug_ctl(o_debug_ctl));

// *** sim/debug_command_gate_runtime_counter_tb.sv ***
/* bench for the command gate; assumes the core model on the read side */
`timescale 1ns/1ps
module debug_command_gate_runtime_counter_tb import dbg_gate_pkg::*;;
	logic        clk = 0, rst_n = 0, vld = 0, rp = 0, wp = 0, bp = 0;
	logic        rv, rj, flag, pcs, rws, rrs;
	logic [7:0]  code = 0, rdat, ctl, wd;
	logic [11:0] addr = 0, radr;
	logic [15:0] dat = 0, pc, rsp, pcw;
	logic [7:0]  nodbg [8] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'hff};
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;
	dbg_core_model core (.i_addr(addr), .o_pc(pc), .o_rdat(rdat));
	debug_command_gate_runtime_counter dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(vld),
		.i_cmd_code(code), .i_cmd_addr(addr), .i_cmd_data(dat), .i_read_protect_option(rp),
		.i_watchpoint_hit(wp), .i_breakpoint_hit(bp), .i_pc_value(pc), .i_reg_rd_data(rdat),
		.o_resp_valid(rv), .o_resp_data(rsp), .o_cmd_rejected(rj), .o_debug_mode_flag(flag),
		.o_debug_ctl(ctl), .o_pc_wr_stb(pcs), .o_pc_wr_data(pcw), .o_reg_wr_stb(rws),
		.o_reg_rd_stb(rrs), .o_reg_addr(radr), .o_reg_wr_data(wd));
	task automatic chk(input string nm, input logic [23:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [11:0] a, input logic [15:0] d,
		input logic ok);
		@(posedge clk);
		#1 {vld, code, addr, dat} = {1'b1, c, a, d};
		@(posedge clk);
		#1 vld = 0;
		chk("answer", {ok, !ok}, {rv, rj});
	endtask
	task automatic hit(input logic w);
		@(posedge clk);
		#1 {wp, bp} = {w, !w};
		@(posedge clk);
		#1 {wp, bp} = 2'b00;
		chk("flag", 1, flag);
	endtask
	task automatic t_idle();
		cmd(8'h00, 0, 0, 1);
		chk("revision", DBG_REVISION, rsp);
		cmd(8'h02, 0, 0, 1);
		chk("idle status", 16'h0000, rsp);
		foreach (nodbg[i]) cmd(nodbg[i], 0, 0, 0);
		cmd(8'h04, 0, 16'h0012, 1);
		cmd(8'h05, 0, 0, 1);
		chk("ctl", 16'h0012, rsp);
		$display("idle done");
	endtask
	task automatic t_dbg();
		hit(0);
		cmd(8'h02, 0, 0, 1);
		chk("status", 16'h0080, rsp);
		cmd(8'h07, 0, 0, 1);
		chk("pc", 16'h4c21, rsp);
		cmd(8'h09, 12'h0c3, 0, 1);
		chk("reg rd", 24'h800066, {rrs, 7'h0, rsp});
		cmd(8'h06, 0, 16'h1357, 1);
		chk("pc wr", 24'h011357, {pcs, pcw});
		cmd(8'h08, 12'h0c3, 16'h0042, 1);
		chk("reg wr", 24'h10c342, {rws, radr, wd});
		$display("debug done");
	endtask
	task automatic t_rp();
		rp = 1;
		cmd(8'h06, 0, 16'h2468, 0);
		cmd(8'h07, 0, 0, 0);
		cmd(8'h09, 0, 0, 0);
		cmd(8'h08, 12'h100, FLASH_MASS_ERASE, 0);
		cmd(8'h08, FLASH_CTL_ADDR, 16'h0012, 0);
		chk("pc kept", 16'h1357, pcw);
		cmd(8'h08, FLASH_CTL_ADDR, FLASH_MASS_ERASE, 1);
		chk("erase", {1'b1, FLASH_CTL_ADDR, FLASH_MASS_ERASE}, {rws, radr, wd});
		cmd(8'h04, 0, 0, 1);
		chk("ctl", 16'h0080, ctl);
		cmd(8'h03, 0, 0, 1);
		rp = 0;
		$display("protect done");
	endtask
	task automatic t_count();
		logic [15:0] c1;
		cmd(8'h04, 0, 0, 1);
		repeat (100) @(posedge clk);
		hit(1);
		cmd(8'h03, 0, 0, 1);
		c1 = rsp;
		cmd(8'h03, 0, 0, 1);
		chk("held", c1, rsp);
		cmd(8'h04, 0, 0, 1);
		repeat (110) @(posedge clk);
		hit(1);
		cmd(8'h03, 0, 0, 1);
		chk("delta", 16'd10, rsp - c1);
		cmd(8'h04, 0, 0, 1);
		repeat (66000) @(posedge clk);
		hit(1);
		cmd(8'h03, 0, 0, 1);
		chk("saturate", CNT_MAX, rsp);
		$display("count done");
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial forever #10 clk = ~clk;
	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		t_idle();
		t_dbg();
		t_rp();
		t_count();
		tally_and_finish();
	end
endmodule

// *** verilog/dbg_gate_pkg.sv ***
/*
 * Constants for the debug command gate and runtime counter.
 * Assumes a single 50 MHz system clock and a command framer on that clock.
 */
package dbg_gate_pkg;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0]  CMD_RD_REV     = 8'h00;
	localparam logic [7:0]  CMD_RSVD       = 8'h01;
	localparam logic [7:0]  CMD_RD_STATUS  = 8'h02;
	localparam logic [7:0]  CMD_RD_RUNTIME = 8'h03;
	localparam logic [7:0]  CMD_WR_CTL     = 8'h04;
	localparam logic [7:0]  CMD_RD_CTL     = 8'h05;
	localparam logic [7:0]  CMD_WR_PC      = 8'h06;
	localparam logic [7:0]  CMD_RD_PC      = 8'h07;
	localparam logic [7:0]  CMD_WR_REG     = 8'h08;
	localparam logic [7:0]  CMD_RD_REG     = 8'h09;

	// ****************************************
	// field layout
	// ****************************************
	localparam int          CTL_DBG_MODE_BIT = 7;
	localparam int          STAT_DBG_MODE_BIT = 7;
	localparam int          STAT_RP_BIT      = 5;
	localparam logic [7:0]  CTL_RESET        = 8'h00;
	localparam logic [15:0] CNT_RESET        = 16'h0000;
	localparam logic [15:0] CNT_MAX          = 16'hffff;

	// ****************************************
	// flash control targets and mass erase
	// ****************************************
	localparam logic [11:0] FLASH_REG_FIRST  = 12'hff8;
	localparam logic [11:0] FLASH_REG_LAST   = 12'hfff;
	localparam logic [11:0] FLASH_CTL_ADDR   = 12'hff8;
	localparam logic [7:0]  FLASH_MASS_ERASE = 8'h63;

	// arbitrary revision value
	localparam logic [15:0] DBG_REVISION     = 16'h0100;

endpackage

// *** verilog/debug_command_gate_runtime_counter.sv ***
/*
 * Debug command decoder, acceptance gate and 16-bit runtime counter.
 * Assumes a serial framer on the same clock hands over one decoded command
 * per i_cmd_valid pulse, and that the core presents register and PC read
 * data combinationally for the address on i_cmd_addr.
 */
`timescale 1ns/1ps

module debug_command_gate_runtime_counter
	import dbg_gate_pkg::*;
(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// command from framer
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [11:0] i_cmd_addr,
	input  wire logic [15:0] i_cmd_data,
	// core side
	input  wire logic        i_read_protect_option,
	input  wire logic        i_watchpoint_hit,
	input  wire logic        i_breakpoint_hit,
	input  wire logic [15:0] i_pc_value,
	input  wire logic [7:0]  i_reg_rd_data,
	// response
	output logic             o_resp_valid,
	output logic [15:0]      o_resp_data,
	output logic             o_cmd_rejected,
	// core control
	output logic             o_debug_mode_flag,
	output logic [7:0]       o_debug_ctl,
	output logic             o_pc_wr_stb,
	output logic [15:0]      o_pc_wr_data,
	output logic             o_reg_wr_stb,
	output logic             o_reg_rd_stb,
	output logic [11:0]      o_reg_addr,
	output logic [7:0]       o_reg_wr_data
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]  ctl;
		logic [15:0] cnt;
		logic        resp_valid;
		logic [15:0] resp_data;
		logic        rejected;
		logic        pc_wr_stb;
		logic [15:0] pc_wr_data;
		logic        reg_wr_stb;
		logic        reg_rd_stb;
		logic [11:0] reg_addr;
		logic [7:0]  reg_wr_data;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ****************************************
	// gate helpers
	// ****************************************
	// read protect comes from the option block on this clock, no sync
	logic       dbg;
	logic       rp;
	logic       accept;
	logic       flash_tgt;
	logic       prot_wr_ok;
	logic       cnt_restart;
	logic       cnt_run;
	logic [7:0] status;

	assign dbg = st_reg.ctl[CTL_DBG_MODE_BIT];
	assign rp  = i_read_protect_option;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.resp_valid = 1'b0;
		st_next.rejected   = 1'b0;
		st_next.pc_wr_stb  = 1'b0;
		st_next.reg_wr_stb = 1'b0;
		st_next.reg_rd_stb = 1'b0;
		flash_tgt = (i_cmd_addr >= FLASH_REG_FIRST) && (i_cmd_addr <= FLASH_REG_LAST);
		status = 8'h00;
		status[STAT_DBG_MODE_BIT] = dbg;
		status[STAT_RP_BIT] = rp;
		prot_wr_ok = flash_tgt &&
			((i_cmd_addr != FLASH_CTL_ADDR) || (i_cmd_data[7:0] == FLASH_MASS_ERASE));

		// ****************************************
		// acceptance gate
		// ****************************************
		// acceptance gate
		case (i_cmd_code)
			CMD_RD_REV, CMD_RD_STATUS: accept = 1'b1;
			CMD_WR_CTL, CMD_RD_CTL:    accept = 1'b1;
			CMD_RD_RUNTIME:            accept = dbg;
			CMD_WR_PC, CMD_RD_PC:      accept = dbg && !rp;
			CMD_RD_REG:                accept = dbg && !rp;
			CMD_WR_REG:                accept = dbg && (!rp || prot_wr_ok);
			default:                   accept = 1'b0;
		endcase

		// ****************************************
		// command execution
		// ****************************************
		// decode and execute
		if (i_cmd_valid && accept) begin
			st_next.resp_valid = 1'b1;
			st_next.resp_data  = 16'h0000;
			case (i_cmd_code)
				CMD_RD_REV:     st_next.resp_data = DBG_REVISION;
				CMD_RD_STATUS:  st_next.resp_data = {8'h00, status};
				CMD_RD_RUNTIME: st_next.resp_data = st_reg.cnt;
				CMD_WR_CTL: begin
					st_next.ctl = i_cmd_data[7:0];
					if (rp && dbg)
						st_next.ctl[CTL_DBG_MODE_BIT] = 1'b1;
				end
				CMD_RD_CTL:     st_next.resp_data = {8'h00, st_reg.ctl};
				CMD_WR_PC: begin
					st_next.pc_wr_stb  = 1'b1;
					st_next.pc_wr_data = i_cmd_data;
				end
				CMD_RD_PC:      st_next.resp_data = i_pc_value;
				CMD_WR_REG: begin
					st_next.reg_wr_stb  = 1'b1;
					st_next.reg_addr    = i_cmd_addr;
					st_next.reg_wr_data = i_cmd_data[7:0];
				end
				CMD_RD_REG: begin
					st_next.reg_rd_stb = 1'b1;
					st_next.reg_addr   = i_cmd_addr;
					st_next.resp_data  = {8'h00, i_reg_rd_data};
				end
				default: st_next.resp_data = 16'h0000;
			endcase
		end else if (i_cmd_valid) begin
			st_next.rejected = 1'b1;
		end

		// ****************************************
		// debug entry
		// ****************************************
		// after the control write, so a same-cycle hit wins
		// watchpoint or breakpoint enters debug
		if (i_watchpoint_hit || i_breakpoint_hit)
			st_next.ctl[CTL_DBG_MODE_BIT] = 1'b1;

		// ****************************************
		// runtime counter
		// ****************************************
		// exit cycle reloads zero, first count one edge later
		// restart on exit
		cnt_restart = dbg && !st_next.ctl[CTL_DBG_MODE_BIT];
		cnt_run     = !dbg && (st_reg.cnt != CNT_MAX);
		if (cnt_restart)
			st_next.cnt = CNT_RESET;
		else if (cnt_run)
			st_next.cnt = st_reg.cnt + 16'h0001;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
			st_reg.ctl <= CTL_RESET;
			st_reg.cnt <= CNT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_resp_valid      = st_reg.resp_valid;
	assign o_resp_data       = st_reg.resp_data;
	assign o_cmd_rejected    = st_reg.rejected;
	assign o_debug_mode_flag = st_reg.ctl[CTL_DBG_MODE_BIT];
	assign o_debug_ctl       = st_reg.ctl;
	assign o_pc_wr_stb       = st_reg.pc_wr_stb;
	assign o_pc_wr_data      = st_reg.pc_wr_data;
	assign o_reg_wr_stb      = st_reg.reg_wr_stb;
	assign o_reg_rd_stb      = st_reg.reg_rd_stb;
	assign o_reg_addr        = st_reg.reg_addr;
	assign o_reg_wr_data     = st_reg.reg_wr_data;

endmodule
